// >>> shared/pfd_pkg.sv
// Shared constants and types for the phase/frequency detector.
package pfd_pkg;

  // Clock and pulse timing.
  localparam int CLK_PERIOD_NS = 25;
  localparam int MIN_PULSE_NS  = 50;
  // A least time rounds up to whole clock cycles.
  localparam int MIN_PULSE_CYC_INT =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Edge pulse width, counted in clock cycles.
  localparam int PULSE_W = 4;
  typedef logic [PULSE_W-1:0] pfd_width_t;
  localparam pfd_width_t WIDTH_ZERO    = pfd_width_t'(0);
  localparam pfd_width_t WIDTH_ONE     = pfd_width_t'(1);
  localparam pfd_width_t MIN_PULSE_CYC = pfd_width_t'(MIN_PULSE_CYC_INT);

  // Reference divider ratio.
  localparam int DIV_W = 16;
  typedef logic [DIV_W-1:0] pfd_div_t;
  localparam pfd_div_t DIV_ZERO = pfd_div_t'(0);
  localparam pfd_div_t DIV_ONE  = pfd_div_t'(1);

  // Positions of the asynchronous pins in the synchroniser bank.
  localparam int PIN_OSC = 0;
  localparam int PIN_FB  = 1;
  localparam int PIN_POL = 2;
  localparam int PIN_CNT = 3;

  // Edge pulse generator states.
  typedef enum logic {
    PFD_IDLE  = 1'b0,
    PFD_PULSE = 1'b1
  } pfd_pulse_state_e;

endpackage

// >>> verilog/pfd_edge_pulse.sv
// Rising-edge detector that stretches each edge into a fixed-width pulse.
`timescale 1ns/1ps
module pfd_edge_pulse (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               level_i,
  input  wire pfd_pkg::pfd_width_t width_i,
  output logic                    rise_o,
  output logic                    pulse_o
);
  import pfd_pkg::*;

  logic             level_prev_reg;
  pfd_pulse_state_e state_reg;
  pfd_pulse_state_e state_next;
  pfd_width_t       cnt_reg;
  pfd_width_t       cnt_next;

  wire              rise_w;
  wire              last_w;
  wire pfd_width_t  width_eff_w;
  wire pfd_width_t  load_w;

  assign rise_w = level_i & ~level_prev_reg;
  assign last_w = (cnt_reg == WIDTH_ZERO);
  // A zero width setting falls back to the nominal minimum.
  assign width_eff_w = (width_i == WIDTH_ZERO) ? MIN_PULSE_CYC : width_i; // R14
  assign load_w = width_eff_w - WIDTH_ONE;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      PFD_IDLE: begin
        if (rise_w) begin
          state_next = PFD_PULSE; // R9
          cnt_next   = load_w;
        end
      end
      PFD_PULSE: begin
        if (rise_w) begin
          cnt_next = load_w;
        end else if (last_w) begin
          state_next = PFD_IDLE;
        end else begin
          cnt_next = cnt_reg - WIDTH_ONE;
        end
      end
      default: begin
        state_next = PFD_IDLE;
        cnt_next   = WIDTH_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_prev_reg <= 1'b0;
      state_reg      <= PFD_IDLE;
      cnt_reg        <= WIDTH_ZERO;
    end else begin
      level_prev_reg <= level_i;
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
    end
  end

  assign rise_o  = rise_w;
  assign pulse_o = (state_reg == PFD_PULSE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_pulse_start: assert property ( // R9
    rise_w |=> pulse_o
  ) else $error("Edge pulse did not start after a rising edge.");

  a_pulse_nominal: assert property ( // R7
    rise_w && width_i == WIDTH_ZERO |=> pulse_o [*2]
  ) else $error("Default edge pulse shorter than the nominal minimum.");

  a_pulse_stop: assert property ( // R14
    pulse_o && last_w && !rise_w |=> !pulse_o
  ) else $error("Edge pulse outlived its programmed width.");

endmodule

// >>> verilog/pfd_ref_divider.sv
// Divides the oscillator pin down to the comparison reference.
`timescale 1ns/1ps
module pfd_ref_divider (
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic            osc_i,
  input  wire pfd_pkg::pfd_div_t ratio_i,
  output logic                 ref_o
);
  import pfd_pkg::*;

  logic      osc_prev_reg;
  logic      ref_reg;
  logic      ref_next;
  pfd_div_t  cnt_reg;
  pfd_div_t  cnt_next;

  wire       osc_rise_w;
  wire       bypass_w;
  wire       wrap_w;
  wire pfd_div_t half_w;

  assign osc_rise_w = osc_i & ~osc_prev_reg;
  // Ratios of zero and one pass the oscillator straight through.
  assign bypass_w = (ratio_i <= DIV_ONE);
  assign wrap_w   = (cnt_reg >= ratio_i - DIV_ONE);
  assign half_w   = ratio_i >> 1;

  always_comb begin
    cnt_next = cnt_reg;
    if (bypass_w) begin
      cnt_next = DIV_ZERO;
    end else if (osc_rise_w) begin
      cnt_next = wrap_w ? DIV_ZERO : cnt_reg + DIV_ONE; // R13
    end
    ref_next = bypass_w ? osc_i : (cnt_next < half_w);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_prev_reg <= 1'b0;
      cnt_reg      <= DIV_ZERO;
      ref_reg      <= 1'b0;
    end else begin
      osc_prev_reg <= osc_i;
      cnt_reg      <= cnt_next;
      ref_reg      <= ref_next;
    end
  end

  assign ref_o = ref_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_div_wrap: assert property ( // R13
    !bypass_w && osc_rise_w && wrap_w |=> cnt_reg == DIV_ZERO
  ) else $error("Reference divider failed to wrap at the ratio.");

  a_div_bypass: assert property ( // R13
    bypass_w |=> ref_o == $past(osc_i)
  ) else $error("Reference divider bypass did not follow the oscillator.");

endmodule

// >>> verilog/pfd_phase_detector.sv
// Phase/frequency detector with lead outputs, three-state error and sum.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Reference before feedback gives a reference-lead pulse as wide as lead.
// R2: Feedback before reference gives a feedback-lead pulse as wide as lead.
// R3: Phase error drives high on reference lead, low on feedback lead.
// R4: Lock sum combines both lead pulses and is always driven.
// R5: Whenever one output shows lead, the other still shows a minimum pulse.
// R6: In lock both lead outputs show a minimum pulse every cycle.
// R7: The minimum pulse width is nominally 50 ns.
// R8: Above output senses hold while polarity select is low.
// R9: Each rising edge of either input makes a fixed-width pulse.
// R10: Reference edge with feedback low sets reference latch; feedback clears.
// R11: Feedback edge with reference low sets feedback latch; reference clears.
// R12: Each edge pulse is ORed into its lead output.
// R13: Reference is the oscillator divided by the programmed ratio.
// R14: The minimum pulse width follows the programmed edge-pulse width.
// R15: Polarity select high swaps the sense of the phase error output.
// R16: Reset clears both latches and floats the phase error output.
module pfd_phase_detector (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               osc_i,
  input  wire logic               fb_i,
  input  wire logic               polarity_select_i,
  input  wire pfd_pkg::pfd_div_t   ref_divide_i,
  input  wire pfd_pkg::pfd_width_t min_width_i,
  output logic                    ref_lead_pulse_o,
  output logic                    fb_lead_pulse_o,
  output logic                    phase_error_o,
  output logic                    phase_error_oe_o,
  output logic                    lock_sum_o,
  output logic                    ref_div_o
);
  import pfd_pkg::*;

  // Pin synchronisers: stage one is read by stage two only.
  logic [PIN_CNT-1:0] pin_meta_reg;
  logic [PIN_CNT-1:0] pin_sync_reg;
  wire  [PIN_CNT-1:0] pin_raw_w;

  assign pin_raw_w[PIN_OSC] = osc_i;
  assign pin_raw_w[PIN_FB]  = fb_i;
  assign pin_raw_w[PIN_POL] = polarity_select_i;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= pin_raw_w[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  wire osc_lvl_w;
  wire fb_lvl_w;
  wire pol_lvl_w;

  assign osc_lvl_w = pin_sync_reg[PIN_OSC];
  assign fb_lvl_w  = pin_sync_reg[PIN_FB];
  assign pol_lvl_w = pin_sync_reg[PIN_POL];

  // Reference divider and the two edge pulse generators.
  wire ref_lvl_w;
  wire ref_rise_w;
  wire ref_pulse_w;
  wire fb_rise_w;
  wire fb_pulse_w;

  // The divider's output flop puts the reference one clock behind the
  // oscillator pin; feedback is compared against that divided edge.
  pfd_ref_divider u_ref_div (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .osc_i   (osc_lvl_w),
    .ratio_i (ref_divide_i), // R13
    .ref_o   (ref_lvl_w)
  );

  pfd_edge_pulse u_ref_edge ( // R7 R9 R14
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .level_i (ref_lvl_w),
    .width_i (min_width_i),
    .rise_o  (ref_rise_w),
    .pulse_o (ref_pulse_w)
  );

  pfd_edge_pulse u_fb_edge ( // R7 R9 R14
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .level_i (fb_lvl_w),
    .width_i (min_width_i),
    .rise_o  (fb_rise_w),
    .pulse_o (fb_pulse_w)
  );

  // Lead latches. Set and clear come from opposite inputs; a set edge
  // is qualified by the other input being low, so both cannot coincide.
  logic ref_lead_reg;
  logic ref_lead_next;
  logic fb_lead_reg;
  logic fb_lead_next;

  wire ref_set_w;
  wire fb_set_w;

  assign ref_set_w = ref_rise_w & ~fb_lvl_w; // R10
  assign fb_set_w  = fb_rise_w & ~ref_lvl_w; // R11

  always_comb begin
    ref_lead_next = ref_lead_reg;
    if (ref_set_w) begin
      ref_lead_next = 1'b1; // R1
    end else if (fb_rise_w) begin
      ref_lead_next = 1'b0; // R10
    end
  end

  always_comb begin
    fb_lead_next = fb_lead_reg;
    if (fb_set_w) begin
      fb_lead_next = 1'b1; // R2
    end else if (ref_rise_w) begin
      fb_lead_next = 1'b0; // R11
    end
  end

  // The edge pulses are ORed in so that a locked loop still shows
  // minimum pulses on both outputs instead of nothing.
  wire ref_out_next_w;
  wire fb_out_next_w;
  wire one_side_w;
  wire up_w;

  assign ref_out_next_w = ref_lead_reg | ref_pulse_w; // R12 R5 R6
  assign fb_out_next_w  = fb_lead_reg | fb_pulse_w;   // R12 R5 R6

  // Coincident pulses mean no net correction, so the error output floats.
  assign one_side_w = ref_out_next_w ^ fb_out_next_w; // R3
  // Low polarity: reference lead pumps up; high polarity swaps the sense.
  assign up_w = ref_out_next_w ^ pol_lvl_w; // R8 R15

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_lead_reg     <= 1'b0; // R16
      fb_lead_reg      <= 1'b0; // R16
      ref_lead_pulse_o <= 1'b0;
      fb_lead_pulse_o  <= 1'b0;
      phase_error_o    <= 1'b0;
      phase_error_oe_o <= 1'b0; // R16
      lock_sum_o       <= 1'b0;
    end else begin
      ref_lead_reg     <= ref_lead_next;
      fb_lead_reg      <= fb_lead_next;
      ref_lead_pulse_o <= ref_out_next_w;
      fb_lead_pulse_o  <= fb_out_next_w;
      phase_error_o    <= one_side_w & up_w;                // R3
      phase_error_oe_o <= one_side_w;                       // R3
      lock_sum_o       <= ref_out_next_w | fb_out_next_w;   // R4
    end
  end

  assign ref_div_o = ref_lvl_w;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_ref_latch_set: assert property ( // R10
    ref_rise_w && !fb_lvl_w |=> ref_lead_reg
  ) else $error("Reference lead latch not set by a leading edge.");

  a_ref_latch_clear: assert property ( // R10
    fb_rise_w && !ref_set_w |=> !ref_lead_reg
  ) else $error("Reference lead latch not cleared by feedback edge.");

  a_fb_latch_set: assert property ( // R11
    fb_rise_w && !ref_lvl_w |=> fb_lead_reg
  ) else $error("Feedback lead latch not set by a leading edge.");

  a_fb_latch_clear: assert property ( // R11
    ref_rise_w && !fb_set_w |=> !fb_lead_reg
  ) else $error("Feedback lead latch not cleared by reference edge.");

  a_ref_lead_width: assert property ( // R1
    ref_lead_reg && !fb_rise_w |=> ref_lead_reg ##1 ref_lead_pulse_o
  ) else $error("Reference lead pulse ended before the feedback edge.");

  a_fb_lead_width: assert property ( // R2
    fb_lead_reg && !ref_rise_w |=> fb_lead_reg ##1 fb_lead_pulse_o
  ) else $error("Feedback lead pulse ended before the reference edge.");

  a_edge_min_ref: assert property ( // R5
    $rose(ref_pulse_w) |=> ref_lead_pulse_o
  ) else $error("Reference edge pulse missing from its lead output.");

  a_edge_min_fb: assert property ( // R6
    $rose(fb_pulse_w) |=> fb_lead_pulse_o
  ) else $error("Feedback edge pulse missing from its lead output.");

  a_err_sense: assert property ( // R3
    ref_lead_pulse_o && !fb_lead_pulse_o
      |-> phase_error_oe_o && phase_error_o == !$past(pol_lvl_w)
  ) else $error("Phase error sense wrong during reference lead.");

  a_err_fb_sense: assert property ( // R15
    fb_lead_pulse_o && !ref_lead_pulse_o
      |-> phase_error_oe_o && phase_error_o == $past(pol_lvl_w)
  ) else $error("Phase error sense wrong during feedback lead.");

  a_err_float: assert property ( // R3
    !(ref_lead_pulse_o ^ fb_lead_pulse_o) |-> !phase_error_oe_o
  ) else $error("Phase error output driven with no net lead.");

  a_sum_driven: assert property ( // R4
    (ref_lead_pulse_o || fb_lead_pulse_o) == lock_sum_o
  ) else $error("Lock sum does not follow the lead outputs.");

  a_reset_clear: assert property ( // R16
    disable iff (1'b0)
    $past(reset_i) |-> !phase_error_oe_o && !ref_lead_reg && !fb_lead_reg
  ) else $error("Reset left a latch set or the error output driven.");

  // The latches change only on an input edge or reset, and never both
  // hold at once, because every edge clears the opposite latch.
  a_lead_exclusive: assert property ( // R1
    !(ref_lead_reg && fb_lead_reg)
  ) else $error("Both lead latches set at once.");

  a_ref_set_cause: assert property ( // R10
    $rose(ref_lead_reg) |-> $past(ref_set_w)
  ) else $error("Reference lead latch set without a leading edge.");

  a_fb_set_cause: assert property ( // R11
    $rose(fb_lead_reg) |-> $past(fb_set_w)
  ) else $error("Feedback lead latch set without a leading edge.");

  a_ref_clear_cause: assert property ( // R10
    $fell(ref_lead_reg) |-> $past(fb_rise_w) || $past(reset_i)
  ) else $error("Reference lead latch cleared without a feedback edge.");

  a_fb_clear_cause: assert property ( // R11
    $fell(fb_lead_reg) |-> $past(ref_rise_w) || $past(reset_i)
  ) else $error("Feedback lead latch cleared without a reference edge.");

  a_ref_lead_out: assert property ( // R1
    $rose(ref_lead_reg) |=> ref_lead_pulse_o
  ) else $error("Reference lead latch did not reach its output.");

  a_fb_lead_out: assert property ( // R2
    $rose(fb_lead_reg) |=> fb_lead_pulse_o
  ) else $error("Feedback lead latch did not reach its output.");

  a_edge_pulse_ref: assert property ( // R9
    ref_rise_w |=> ref_pulse_w
  ) else $error("Reference edge made no edge pulse.");

  a_edge_pulse_fb: assert property ( // R9
    fb_rise_w |=> fb_pulse_w
  ) else $error("Feedback edge made no edge pulse.");

  // A closing edge must still show its own minimum pulse.
  a_fb_min_pulse: assert property ( // R5
    fb_rise_w && ref_lead_reg |-> ##2 fb_lead_pulse_o
  ) else $error("No feedback minimum pulse after a reference lead.");

  a_ref_min_pulse: assert property ( // R5
    ref_rise_w && fb_lead_reg |-> ##2 ref_lead_pulse_o
  ) else $error("No reference minimum pulse after a feedback lead.");

  a_ref_pulse_or: assert property ( // R12
    ref_pulse_w |=> ref_lead_pulse_o
  ) else $error("Reference edge pulse not seen on its lead output.");

  a_fb_pulse_or: assert property ( // R12
    fb_pulse_w |=> fb_lead_pulse_o
  ) else $error("Feedback edge pulse not seen on its lead output.");

  // Coincident edges are the locked case: latches stay clear and the
  // matched pulses must not drive the error output.
  a_lock_clears: assert property ( // R6
    ref_rise_w && fb_rise_w |=> !ref_lead_reg && !fb_lead_reg
  ) else $error("Coincident edges left a lead latch set.");

  a_lock_quiet: assert property ( // R6
    ref_rise_w && fb_rise_w |-> ##2 !phase_error_oe_o
  ) else $error("Coincident edges drove the phase error output.");

  a_err_one_side: assert property ( // R3
    phase_error_oe_o |-> ref_lead_pulse_o != fb_lead_pulse_o
  ) else $error("Phase error driven while both or neither side is high.");

  // With exactly one side high, the data bit names which side it is.
  a_err_plain: assert property ( // R8
    phase_error_oe_o && !$past(pol_lvl_w)
      |-> phase_error_o == ref_lead_pulse_o
  ) else $error("Phase error sense wrong with polarity select low.");

  a_err_swapped: assert property ( // R15
    phase_error_oe_o && $past(pol_lvl_w)
      |-> phase_error_o == fb_lead_pulse_o
  ) else $error("Phase error sense wrong with polarity select high.");

endmodule

// >>> testbench/pfd_vco_model.sv
// Behavioural oscillator model that drives the divided feedback pin.
`timescale 1ns/1ps
module pfd_vco_model (
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] delay_i,
  output logic            fb_o
);
  // The count rests at its ceiling, pin low, until the first fire.
  int count = 100;

  // The count moves on the rising edge and the pin changes on the falling
  // edge, so the detector never samples the pin in the step it changes.
  always @(posedge clk_i) begin
    if (fire_i)
      count <= 0;
    else if (count < 100)
      count <= count + 1;
  end

  always @(negedge clk_i) begin
    fb_o <= (count >= int'(delay_i)) && (count < int'(delay_i) + 8);
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the phase/frequency detector.
`timescale 1ns/1ps
module testbench;
  import pfd_pkg::*;
  logic       clk_i;
  logic       reset_i;
  logic       osc_i;
  logic       fb_i;
  logic       polarity_select;
  logic       fire;
  logic [7:0] dly;
  pfd_div_t   ratio;
  pfd_width_t wid;
  logic       rl;
  logic       fl;
  logic       pe;
  logic       oe;
  logic       ls;
  logic       rd;
  int         err_total = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         rc, fc, hi, lo, sc;
  // The divider's output flop puts the reference one clock behind its
  // pin, so the pin is driven that much early to line up with feedback.
  localparam int REF_LAG = 1;

  pfd_phase_detector DUT (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .osc_i            (osc_i),
    .fb_i             (fb_i),
    .polarity_select_i(polarity_select),
    .ref_divide_i     (ratio),
    .min_width_i      (wid),
    .ref_lead_pulse_o (rl),
    .fb_lead_pulse_o  (fl),
    .phase_error_o    (pe),
    .phase_error_oe_o (oe),
    .lock_sum_o       (ls),
    .ref_div_o        (rd)
  );

  pfd_vco_model VCO (
    .clk_i  (clk_i),
    .fire_i (fire),
    .delay_i(dly),
    .fb_o   (fb_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // A hang is cut short well after the whole sequence should have ended.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(string what, int exp, int got);
    n_tests++;
    if (exp !== got) begin
      err_total++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    n_tests++;
    if (exp !== got) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Reference edge lands at cycle r, feedback pin at cycle f (both >= 1);
  // counts the cycles each output shows its active state.
  task automatic pair(int r, int f);
    rc = 0;
    fc = 0;
    hi = 0;
    lo = 0;
    sc = 0;
    dly = 8'(f - 1);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      fire = (i == 0);
      osc_i = (i + REF_LAG >= r) && (i + REF_LAG < r + 8);
      rc += int'(rl === 1'b1);
      fc += int'(fl === 1'b1);
      hi += int'(oe === 1'b1 && pe === 1'b1);
      lo += int'(oe === 1'b1 && pe === 1'b0);
      sc += int'(ls === 1'b1);
    end
  endtask

  task automatic t_ref_lead(int d);
    pair(1, 1 + d);
    check("ref lead width", d, rc);
    check("fb min width", 2, fc);
    check("error high", d, hi);
    check("error low", 2, lo);
    check("lock sum", d + 2, sc);
  endtask

  task automatic t_fb_lead(int d);
    pair(1 + d, 1);
    check("fb lead width", d, fc);
    check("ref min width", 2, rc);
    check("error high", 2, hi);
    check("error low", d, lo);
    check("lock sum", d + 2, sc);
  endtask

  task automatic t_lock(pfd_width_t w, int exp_w);
    wid = w;
    pair(1, 1);
    check("locked ref width", exp_w, rc);
    check("locked fb width", exp_w, fc);
    check("locked error", 0, hi + lo);
    check("locked sum", exp_w, sc);
    wid = WIDTH_ZERO;
  endtask

  task automatic t_polarity();
    polarity_select = 1'b1;
    repeat (4) @(negedge clk_i);
    pair(1, 6);
    check("swapped high", 2, hi);
    check("swapped low", 5, lo);
    polarity_select = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  // Sixteen oscillator rises with a ratio of four give four reference rises.
  task automatic t_divider();
    int rises;
    logic last;
    rises = 0;
    // Leaving bypass lifts the output at once; let that settle first.
    ratio = 16'h0004;
    repeat (2) @(negedge clk_i);
    last = rd;
    for (int i = 0; i < 80; i++) begin
      @(negedge clk_i);
      osc_i = (i < 64) && (i % 4 < 2);
      rises += int'(rd === 1'b1 && last === 1'b0);
      last = rd;
    end
    check("divided rises", 4, rises);
    ratio = DIV_ZERO;
  endtask

  task automatic t_reset();
    @(negedge clk_i);
    osc_i = 1'b1;
    repeat (7) @(negedge clk_i);
    check_bit("lead before reset", 1'b1, rl);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check_bit("ref lead", 1'b0, rl);
    check_bit("fb lead", 1'b0, fl);
    check_bit("error enable", 1'b0, oe);
    check_bit("lock sum", 1'b0, ls);
    osc_i = 1'b0;
    reset_i = 1'b0;
    repeat (10) @(negedge clk_i);
  endtask

  initial begin
    reset_i = 1'b1;
    osc_i = 1'b0;
    polarity_select = 1'b0;
    fire = 1'b0;
    dly = 8'h00;
    ratio = DIV_ZERO;
    wid = WIDTH_ZERO;
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check_bit("idle error enable", 1'b0, oe);
    t_ref_lead(5);
    t_ref_lead(7);
    t_fb_lead(6);
    t_lock(WIDTH_ZERO, 2);
    t_lock(pfd_width_t'(3), 3);
    t_polarity();
    t_divider();
    t_reset();
    report_and_stop();
  end
endmodule
